// ### deac_params.svh
// Constants for the data EEPROM access controller
// Functional notes
// - 128 bytes stored, locations 00h through 7Fh
// - Array reached only through four registers
// - Byte write erases location, then programs
// - Internal timer sets write length, hardware signals
// - Protection blocks programmer, CPU access unchanged
// - Data register holds write byte, read result
// - Only address bits six to zero select
// - Control bits seven to four read zero
// - Read/write start bits set-only, hardware clears
// - Writes need write enable, cleared at power-up
// - Reset without power_on_reset during write sets write error flag
// - Interrupted write clears data, address; error readable
// - Completion sets flag, only software clears
// - Unlock register has no storage, reads zero
// - Read result in data register next cycle
// - Write needs 55h, AAh, start in sequence
// - Start refused without enable; later clear harmless
// - No writes while power-up timer runs
`ifndef DEAC_PARAMS_SVH
`define DEAC_PARAMS_SVH
// ------------------------------------------------------------
// Register indices (byte address is four times the index)
// ------------------------------------------------------------
`define DEAC_IDX_IRQ    10'h00c
`define DEAC_IDX_DATA   10'h09a
`define DEAC_IDX_ADDR   10'h09b
`define DEAC_IDX_CTRL   10'h09c
`define DEAC_IDX_UNLK   10'h09d
// ------------------------------------------------------------
// Fields and reset values
// ------------------------------------------------------------
`define DEAC_CTRL_RD    0
`define DEAC_CTRL_WR    1
`define DEAC_CTRL_WRITE_ENABLE_BIT  2
`define DEAC_CTRL_WRITE_ERROR_FLAG 3
`define DEAC_IRQ_WCF    7
`define DEAC_BYTE_RST   8'h00
`define DEAC_KEY_FIRST  8'h55
`define DEAC_KEY_SECOND 8'haa
`define DEAC_ERASED     8'hff
`define DEAC_RESP_OKAY  2'h0
`define DEAC_RESP_SLV   2'h2
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define DEAC_CLK_HZ     40000000
`define DEAC_WRITE_US   5000
`define DEAC_PWRUP_MS   72
`define DEAC_UNLOCK_GAP 16
`endif

// ### deac_pkg.sv
// Types shared by the data EEPROM access controller
package deac_pkg;
   typedef enum logic [1:0] {UNL_IDLE, UNL_GOT_FIRST, UNL_ARMED} deac_unl_e;
   typedef enum logic [1:0] {WP_IDLE, WP_ERASE, WP_PROGRAM} deac_wphase_e;
   typedef logic [7:0] deac_byte_t;
endpackage

// ### deac_nv_array.sv
// Nonvolatile byte array with its erase/program write timer
`timescale 1ns/1ps
`include "deac_params.svh"
module deac_nv_array #(
   parameter int DEPTH        = 128,
   parameter int AW           = 7,
   parameter int WRITE_CYCLES = 200000
) (
   // Clock and reset
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   // Read ports
   input  wire logic [AW-1:0]        rd_addr,
   output deac_pkg::deac_byte_t      rd_data,
   input  wire logic [AW-1:0]        prog_addr,
   output deac_pkg::deac_byte_t      prog_data,
   // Write request
   input  wire logic                 wr_start,
   input  wire logic [AW-1:0]        wr_addr,
   input  wire deac_pkg::deac_byte_t wr_data,
   output logic                      busy,
   output logic                      done
);
   localparam int CW = $clog2(WRITE_CYCLES + 1);
   deac_pkg::deac_byte_t   mem_q [DEPTH];
   deac_pkg::deac_wphase_e ph_q;
   logic [CW-1:0]          cnt_q;
   logic [AW-1:0]          a_q;
   deac_pkg::deac_byte_t   d_q;
   logic                   done_q;
   wire start_ok = wr_start && ph_q == deac_pkg::WP_IDLE;
   wire last     = cnt_q == CW'(WRITE_CYCLES - 1);
   assign rd_data   = mem_q[rd_addr];
   assign prog_data = mem_q[prog_addr];
   assign busy      = ph_q != deac_pkg::WP_IDLE;
   assign done      = done_q;
   // ------------------------------------------------------------
   // Write timer
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      done_q <= 1'b0;
      if (!aresetn) begin
         ph_q  <= deac_pkg::WP_IDLE;
         cnt_q <= '0;
      end else begin
         unique case (ph_q)
            deac_pkg::WP_IDLE: if (wr_start) begin
               ph_q  <= deac_pkg::WP_ERASE;
               cnt_q <= '0;
            end
            deac_pkg::WP_ERASE: begin
               ph_q  <= deac_pkg::WP_PROGRAM;
               cnt_q <= cnt_q + 1'b1;
            end
            deac_pkg::WP_PROGRAM: begin
               cnt_q <= cnt_q + 1'b1;
               if (last) begin
                  ph_q   <= deac_pkg::WP_IDLE;
                  done_q <= 1'b1;
               end
            end
         endcase
      end
   end
   // Latched at start so later bus writes cannot disturb it
   always_ff @(posedge aclk) begin
      if (start_ok) begin
         a_q <= wr_addr;
         d_q <= wr_data;
      end
   end
   // Contents survive reset; a cut write leaves the cell erased
   always_ff @(posedge aclk) begin
      if (ph_q == deac_pkg::WP_ERASE) begin
         mem_q[a_q] <= `DEAC_ERASED;
      end else if (ph_q == deac_pkg::WP_PROGRAM && last) begin
         mem_q[a_q] <= d_q;
      end
   end
   sequence s_start;
      start_ok;
   endsequence
   sequence s_erase;
      ph_q == deac_pkg::WP_ERASE ##1 mem_q[a_q] == `DEAC_ERASED;
   endsequence
   erase_first_a: assert property (
      @(posedge aclk) disable iff (!aresetn) s_start |=> s_erase)
      else $error("write did not erase first");
   timer_bound_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      busy |-> cnt_q < CW'(WRITE_CYCLES))
      else $error("write timer overran");
   done_busy_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      done |-> $past(busy) && !busy)
      else $error("completion without write");
endmodule

// ### deac_unlock.sv
// Two-key unlock sequence checker for byte writes
`timescale 1ns/1ps
`include "deac_params.svh"
module deac_unlock #(
   parameter int GAP = 16
) (
   // Clock and reset
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   // Register write strobes
   input  wire logic                 key_wr,
   input  wire deac_pkg::deac_byte_t key_data,
   input  wire logic                 other_wr,
   // Result
   output logic                      armed
);
   localparam int GW = $clog2(GAP + 1);
   deac_pkg::deac_unl_e st_q;
   deac_pkg::deac_unl_e st_d;
   logic [GW-1:0]       gap_q;
   wire k1      = key_wr && key_data == `DEAC_KEY_FIRST;
   wire k2      = key_wr && key_data == `DEAC_KEY_SECOND;
   wire gap_out = gap_q == GW'(GAP - 1);
   assign armed = st_q == deac_pkg::UNL_ARMED;
   // Any stray write or a slow step drops the sequence
   always_comb begin
      st_d = st_q;
      unique case (st_q)
         deac_pkg::UNL_IDLE: if (k1) begin
            st_d = deac_pkg::UNL_GOT_FIRST;
         end
         deac_pkg::UNL_GOT_FIRST: begin
            if (key_wr) begin
               st_d = k2 ? deac_pkg::UNL_ARMED : deac_pkg::UNL_IDLE;
            end else if (other_wr || gap_out) begin
               st_d = deac_pkg::UNL_IDLE;
            end
         end
         deac_pkg::UNL_ARMED: begin
            if (k1) begin
               st_d = deac_pkg::UNL_GOT_FIRST;
            end else if (key_wr || other_wr || gap_out) begin
               st_d = deac_pkg::UNL_IDLE;
            end
         end
      endcase
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q  <= deac_pkg::UNL_IDLE;
         gap_q <= '0;
      end else begin
         st_q  <= st_d;
         gap_q <= (st_d != st_q || gap_out) ? '0 : gap_q + 1'b1;
      end
   end
   sequence s_keys;
      st_q == deac_pkg::UNL_GOT_FIRST && k2;
   endsequence
   arm_keys_a: assert property (
      @(posedge aclk) disable iff (!aresetn) s_keys |=> armed)
      else $error("keys did not arm");
   arm_cause_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      $rose(armed) |-> $past(k2))
      else $error("armed without second key");
endmodule

// ### deac_top.sv
// Data EEPROM access controller with an AXI4-Lite register slave
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "deac_params.svh"
module deac_top #(
   parameter int DEPTH        = 128,
   parameter int WRITE_CYCLES = `DEAC_WRITE_US * (`DEAC_CLK_HZ / 1000000),
   parameter int PWRUP_CYCLES = `DEAC_PWRUP_MS * (`DEAC_CLK_HZ / 1000),
   parameter int UNLOCK_GAP   = `DEAC_UNLOCK_GAP
) (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        power_on_reset,
   // Write address
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [11:0] awaddr,
   input  wire logic [2:0]  awprot,
   // Write data
   input  wire logic        wvalid,
   output logic             wready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   // Write response
   output logic             bvalid,
   input  wire logic        bready,
   output logic [1:0]       bresp,
   // Read address
   input  wire logic        arvalid,
   output logic             arready,
   input  wire logic [11:0] araddr,
   input  wire logic [2:0]  arprot,
   // Read data
   output logic             rvalid,
   input  wire logic        rready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   // Device programmer port
   input  wire logic        data_protect,
   input  wire logic        prog_rd_req,
   input  wire logic [6:0]  prog_addr,
   output logic [7:0]       prog_rdata,
   output logic             prog_rd_done,
   output logic             prog_denied,
   // Status
   output logic             write_busy
);
   localparam int AW = $clog2(DEPTH);
   localparam int PW = $clog2(PWRUP_CYCLES + 1);
   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   function automatic logic hit(input logic [11:0] a,
                                input logic [9:0]  idx);
      return a[11:2] == idx;
   endfunction
   logic                 aw_full_q;
   logic                 w_full_q;
   logic [11:0]          aw_addr_q;
   logic [31:0]          w_data_q;
   logic [3:0]           w_strb_q;
   logic                 bvalid_q;
   logic [1:0]           bresp_q;
   logic                 rvalid_q;
   logic [31:0]          rdata_q;
   logic [1:0]           rresp_q;
   deac_pkg::deac_byte_t data_q;
   deac_pkg::deac_byte_t addr_q;
   logic                 rd_q;
   logic                 write_enable_bit_q;
   logic                 write_error_flag_q;
   logic                 wcf_q;
   logic [PW-1:0]        pwrup_q;
   logic                 cut_q;
   deac_pkg::deac_byte_t prog_q;
   logic                 prog_done_q;
   logic                 prog_deny_q;
   deac_pkg::deac_byte_t arr_rd;
   deac_pkg::deac_byte_t arr_prog;
   logic                 arr_busy;
   logic                 arr_done;
   logic                 armed;
   wire aw_hs   = awvalid && awready;
   wire w_hs    = wvalid && wready;
   wire ar_hs   = arvalid && arready;
   wire wr_fire = aw_full_q && w_full_q && !bvalid_q;
   wire lo_wr   = wr_fire && w_strb_q[0];
   wire [7:0] wb = w_data_q[7:0];
   wire ws_irq  = hit(aw_addr_q, `DEAC_IDX_IRQ);
   wire ws_data = hit(aw_addr_q, `DEAC_IDX_DATA);
   wire ws_addr = hit(aw_addr_q, `DEAC_IDX_ADDR);
   wire ws_ctrl = hit(aw_addr_q, `DEAC_IDX_CTRL);
   wire ws_unlk = hit(aw_addr_q, `DEAC_IDX_UNLK);
   wire ws_map  = ws_irq || ws_data || ws_addr || ws_ctrl || ws_unlk;
   wire rs_irq  = hit(araddr, `DEAC_IDX_IRQ);
   wire rs_data = hit(araddr, `DEAC_IDX_DATA);
   wire rs_addr = hit(araddr, `DEAC_IDX_ADDR);
   wire rs_ctrl = hit(araddr, `DEAC_IDX_CTRL);
   wire rs_unlk = hit(araddr, `DEAC_IDX_UNLK);
   wire rs_map  = rs_irq || rs_data || rs_addr || rs_ctrl || rs_unlk;
   wire ctrl_wr = lo_wr && ws_ctrl;
   wire key_wr  = lo_wr && ws_unlk;
   wire pwrup_busy = pwrup_q != '0;
   // Start refused without enable, keys, or while busy
   wire wr_start = ctrl_wr && wb[`DEAC_CTRL_WR] && write_enable_bit_q && armed
                   && !pwrup_busy && !arr_busy;
   // Upper nibble unimplemented, reads as zero
   wire [7:0] ctrl_rd = {4'h0, write_error_flag_q, write_enable_bit_q, arr_busy, rd_q};
   wire [7:0] irq_rd  = {wcf_q, 7'h00};
   // No storage behind the unlock register
   wire [7:0] r_byte  = rs_irq  ? irq_rd  :
                        rs_data ? data_q  :
                        rs_addr ? addr_q  :
                        rs_ctrl ? ctrl_rd : 8'h00;
   assign awready    = !aw_full_q;
   assign wready     = !w_full_q;
   assign bvalid     = bvalid_q;
   assign bresp      = bresp_q;
   assign arready    = !rvalid_q;
   assign rvalid     = rvalid_q;
   assign rdata      = rdata_q;
   assign rresp      = rresp_q;
   assign write_busy = arr_busy;
   assign prog_rdata   = prog_q;
   assign prog_rd_done = prog_done_q;
   assign prog_denied  = prog_deny_q;
   // ------------------------------------------------------------
   // AXI4-Lite channels
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q <= 1'b0;
         w_full_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= `DEAC_RESP_OKAY;
      end else begin
         if (aw_hs) begin
            aw_full_q <= 1'b1;
            aw_addr_q <= awaddr;
         end else if (wr_fire) begin
            aw_full_q <= 1'b0;
         end
         if (w_hs) begin
            w_full_q <= 1'b1;
            w_data_q <= wdata;
            w_strb_q <= wstrb;
         end else if (wr_fire) begin
            w_full_q <= 1'b0;
         end
         if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= ws_map ? `DEAC_RESP_OKAY : `DEAC_RESP_SLV;
         end else if (bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q  <= '0;
         rresp_q  <= `DEAC_RESP_OKAY;
      end else if (ar_hs) begin
         rvalid_q <= 1'b1;
         rdata_q  <= {24'h000000, r_byte};
         rresp_q  <= rs_map ? `DEAC_RESP_OKAY : `DEAC_RESP_SLV;
      end else if (rready) begin
         rvalid_q <= 1'b0;
      end
   end
   // ------------------------------------------------------------
   // Data, address and control registers
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         data_q <= `DEAC_BYTE_RST;
         addr_q <= `DEAC_BYTE_RST;
      end else begin
         if (rd_q) begin
            data_q <= arr_rd;
         end else if (lo_wr && ws_data) begin
            data_q <= wb;
         end
         if (lo_wr && ws_addr) begin
            addr_q <= wb;
         end
      end
   end
   // Software may set start bits, never clear them
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_q   <= 1'b0;
         write_enable_bit_q <= 1'b0;
      end else begin
         rd_q <= ctrl_wr && wb[`DEAC_CTRL_RD];
         if (ctrl_wr) begin
            write_enable_bit_q <= wb[`DEAC_CTRL_WRITE_ENABLE_BIT];
         end
      end
   end
   // Error flag survives a reset without power_on_reset so software can see a cut write
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         write_error_flag_q <= power_on_reset ? 1'b0 : (write_error_flag_q | arr_busy);
         cut_q   <= power_on_reset ? 1'b0 : (cut_q | arr_busy);
      end else if (ctrl_wr) begin
         write_error_flag_q <= wb[`DEAC_CTRL_WRITE_ERROR_FLAG];
         cut_q   <= 1'b0;
      end
   end
   // Completion flag: a set wins over a software clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wcf_q <= 1'b0;
      end else if (arr_done) begin
         wcf_q <= 1'b1;
      end else if (lo_wr && ws_irq) begin
         wcf_q <= wb[`DEAC_IRQ_WCF];
      end
   end
   // Power-up timer runs only after a power-on reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pwrup_q <= power_on_reset ? PW'(PWRUP_CYCLES) : '0;
      end else if (pwrup_busy) begin
         pwrup_q <= pwrup_q - 1'b1;
      end
   end
   // Programmer reads blocked under protection, CPU unaffected
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prog_q      <= `DEAC_BYTE_RST;
         prog_done_q <= 1'b0;
         prog_deny_q <= 1'b0;
      end else begin
         prog_done_q <= prog_rd_req;
         prog_deny_q <= prog_rd_req && data_protect;
         if (prog_rd_req) begin
            prog_q <= data_protect ? 8'h00 : arr_prog;
         end
      end
   end
   // ------------------------------------------------------------
   // Array and unlock checker
   // ------------------------------------------------------------
   deac_nv_array #(
      .DEPTH        (DEPTH),
      .AW           (AW),
      .WRITE_CYCLES (WRITE_CYCLES)
   ) u_array (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .rd_addr   (addr_q[AW-1:0]),
      .rd_data   (arr_rd),
      .prog_addr (prog_addr[AW-1:0]),
      .prog_data (arr_prog),
      .wr_start  (wr_start),
      .wr_addr   (addr_q[AW-1:0]),
      .wr_data   (data_q),
      .busy      (arr_busy),
      .done      (arr_done)
   );
   deac_unlock #(
      .GAP (UNLOCK_GAP)
   ) u_unlock (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .key_wr   (key_wr),
      .key_data (wb),
      .other_wr (lo_wr && !ws_unlk),
      .armed    (armed)
   );
   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   rd_load_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      ctrl_wr && wb[`DEAC_CTRL_RD] |=> rd_q ##1 data_q == $past(arr_rd))
      else $error("read byte not loaded next cycle");
   start_gate_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      !arr_busy && !write_enable_bit_q && ctrl_wr |=> !arr_busy)
      else $error("write started without enable");
   no_abort_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      arr_busy && ctrl_wr && !wb[`DEAC_CTRL_WR] |=> arr_busy || arr_done)
      else $error("software cut a write short");
   pwrup_block_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      pwrup_busy && !arr_busy |=> !arr_busy)
      else $error("write during power-up");
   ctrl_zero_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      ar_hs && rs_ctrl |=> rvalid_q && rdata_q[31:4] == 28'h0000000)
      else $error("control upper bits not zero");
   unlock_zero_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      ar_hs && rs_unlk |=> rdata_q == 32'h00000000)
      else $error("unlock register read nonzero");
   done_flag_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      arr_done |=> wcf_q && !arr_busy)
      else $error("completion flag not set");
   cut_error_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) && cut_q |-> write_error_flag_q && data_q == 8'h00
                                  && addr_q == 8'h00)
      else $error("cut write not reported");
endmodule

// ### deac_prog_model.sv
// Device programmer model on the read-only programmer port
`timescale 1ns/1ps
module deac_prog_model (
   // Clock
   input  wire logic       aclk,
   // Bench control
   input  wire logic       go,
   input  wire logic [6:0] go_addr,
   // Programmer port
   output logic            prog_rd_req,
   output logic [6:0]      prog_addr,
   input  wire logic [7:0] prog_rdata,
   input  wire logic       prog_rd_done,
   input  wire logic       prog_denied,
   // Captured answer
   output logic [7:0]      got_data,
   output logic            got_denied
);
   initial begin
      prog_rd_req = 1'b0;
      prog_addr = 7'h00;
      got_data = 8'h00;
      got_denied = 1'b0;
   end
   // Address flips when idle, so a stale value is never trusted
   always @(posedge aclk) begin
      prog_rd_req <= go;
      prog_addr <= go ? go_addr : ~prog_addr;
      if (prog_rd_done) begin
         got_data <= prog_rdata;
         got_denied <= prog_denied;
      end
   end
endmodule

// ### tb_top.sv
// Register-level testbench of the data EEPROM access controller
`timescale 1ns/1ps
`include "deac_params.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; \
   $display("ERROR %s expected %h seen %h", n, e, g); end end
module tb_top;
   // -------------------------------------------------------------
   // Signals
   // -------------------------------------------------------------
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic        power_on_reset = 1'b1;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic [31:0] wdata = 32'h0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic        data_protect = 1'b0, go = 1'b0;
   logic [6:0]  go_addr = 7'h00, prog_addr;
   logic        prog_rd_req, prog_rd_done, prog_denied, write_busy;
   logic [7:0]  prog_rdata, got_data;
   logic        got_denied;
   logic [1:0]  rsp;
   logic [31:0] d;
   int          checks = 0, miscompares = 0, cyc = 0;
   always #12.5 aclk = ~aclk;
   // Short write timer keeps the run brief
   deac_top #(.WRITE_CYCLES(20), .PWRUP_CYCLES(40)) u_dut (
      .aclk(aclk), .aresetn(aresetn), .power_on_reset(power_on_reset),
      .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
      .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
      .wstrb(4'h1), .bvalid(bvalid), .bready(bready), .bresp(bresp),
      .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
      .rresp(rresp), .data_protect(data_protect),
      .prog_rd_req(prog_rd_req), .prog_addr(prog_addr),
      .prog_rdata(prog_rdata), .prog_rd_done(prog_rd_done),
      .prog_denied(prog_denied), .write_busy(write_busy));
   deac_prog_model u_prog (
      .aclk(aclk), .go(go), .go_addr(go_addr),
      .prog_rd_req(prog_rd_req), .prog_addr(prog_addr),
      .prog_rdata(prog_rdata), .prog_rd_done(prog_rd_done),
      .prog_denied(prog_denied), .got_data(got_data),
      .got_denied(got_denied));
   // -------------------------------------------------------------
   // Bus tasks
   // -------------------------------------------------------------
   task automatic wr(input logic [9:0] idx, input logic [7:0] b);
      @(posedge aclk);
      awvalid <= 1'b1;
      awaddr <= {idx, 2'b00};
      wvalid <= 1'b1;
      wdata <= {24'h0, b};
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
      rsp = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [9:0] idx);
      @(posedge aclk);
      arvalid <= 1'b1;
      araddr <= {idx, 2'b00};
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid);
      d = rdata;
      rsp = rresp;
      rready <= 1'b0;
   endtask
   task automatic rd_chk(input logic [9:0] idx, input logic [7:0] e);
      rd(idx);
      `CHK("rdata", {24'h0, e}, d)
   endtask
   task automatic start_write();
      wr(`DEAC_IDX_UNLK, `DEAC_KEY_FIRST);
      wr(`DEAC_IDX_UNLK, `DEAC_KEY_SECOND);
      wr(`DEAC_IDX_CTRL, 8'h06);
   endtask
   task automatic prog_rd(input logic [6:0] a);
      @(posedge aclk);
      go <= 1'b1;
      go_addr <= a;
      @(posedge aclk);
      go <= 1'b0;
      repeat (4) @(posedge aclk);
   endtask
   task automatic report_and_stop();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Hang guard
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 4000) begin
         miscompares++;
         report_and_stop();
      end
   end
   // -------------------------------------------------------------
   // Tests
   // -------------------------------------------------------------
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      rd_chk(`DEAC_IDX_IRQ, 8'h00);
      rd_chk(`DEAC_IDX_DATA, 8'h00);
      rd_chk(`DEAC_IDX_ADDR, 8'h00);
      rd_chk(`DEAC_IDX_CTRL, 8'h00);
      // Power-up timer still running: armed start must be refused
      wr(`DEAC_IDX_CTRL, 8'h04);
      start_write();
      rd_chk(`DEAC_IDX_CTRL, 8'h04);
      wr(`DEAC_IDX_CTRL, 8'h00);
      rd(10'h100);
      `CHK("rresp", `DEAC_RESP_SLV, rsp)
      wr(10'h100, 8'h12);
      `CHK("bresp", `DEAC_RESP_SLV, rsp)
      // Lone second key leaves the sequence idle
      wr(`DEAC_IDX_UNLK, `DEAC_KEY_SECOND);
      rd_chk(`DEAC_IDX_UNLK, 8'h00);
      // Write enable still clear: start must be refused
      start_write();
      rd_chk(`DEAC_IDX_CTRL, 8'h04);
      wr(`DEAC_IDX_CTRL, 8'hf4);
      rd_chk(`DEAC_IDX_CTRL, 8'h04);
      wr(`DEAC_IDX_ADDR, 8'h85);
      wr(`DEAC_IDX_DATA, 8'h3c);
      start_write();
      rd_chk(`DEAC_IDX_CTRL, 8'h06);
      wr(`DEAC_IDX_DATA, 8'h99);
      wr(`DEAC_IDX_CTRL, 8'h04);
      rd_chk(`DEAC_IDX_CTRL, 8'h06);
      while (write_busy !== 1'b0) @(posedge aclk);
      rd_chk(`DEAC_IDX_CTRL, 8'h04);
      rd_chk(`DEAC_IDX_IRQ, 8'h80);
      wr(`DEAC_IDX_IRQ, 8'h00);
      rd_chk(`DEAC_IDX_IRQ, 8'h00);
      // Address bit seven ignored: read back through 05h
      wr(`DEAC_IDX_ADDR, 8'h05);
      wr(`DEAC_IDX_CTRL, 8'h05);
      rd_chk(`DEAC_IDX_DATA, 8'h3c);
      rd_chk(`DEAC_IDX_CTRL, 8'h04);
      prog_rd(7'h05);
      `CHK("prog_data", 8'h3c, got_data)
      `CHK("prog_denied", 1'b0, got_denied)
      data_protect <= 1'b1;
      prog_rd(7'h05);
      `CHK("prog_data", 8'h00, got_data)
      `CHK("prog_denied", 1'b1, got_denied)
      // Another register write breaks the unlock sequence
      wr(`DEAC_IDX_UNLK, `DEAC_KEY_FIRST);
      wr(`DEAC_IDX_ADDR, 8'h05);
      wr(`DEAC_IDX_UNLK, `DEAC_KEY_SECOND);
      wr(`DEAC_IDX_CTRL, 8'h06);
      rd_chk(`DEAC_IDX_CTRL, 8'h04);
      // Reset in mid-write leaves the error flag
      wr(`DEAC_IDX_DATA, 8'h5a);
      start_write();
      `CHK("write_busy", 1'b1, write_busy)
      aresetn <= 1'b0;
      power_on_reset <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd_chk(`DEAC_IDX_CTRL, 8'h08);
      rd_chk(`DEAC_IDX_DATA, 8'h00);
      rd_chk(`DEAC_IDX_ADDR, 8'h00);
      wr(`DEAC_IDX_CTRL, 8'h00);
      rd_chk(`DEAC_IDX_CTRL, 8'h00);
      wr(`DEAC_IDX_ADDR, 8'h05);
      wr(`DEAC_IDX_CTRL, 8'h01);
      rd_chk(`DEAC_IDX_DATA, `DEAC_ERASED);
      // Retry of the cut write after reloading data
      wr(`DEAC_IDX_DATA, 8'h5a);
      wr(`DEAC_IDX_CTRL, 8'h04);
      start_write();
      while (write_busy !== 1'b0) @(posedge aclk);
      wr(`DEAC_IDX_CTRL, 8'h05);
      rd_chk(`DEAC_IDX_DATA, 8'h5a);
      report_and_stop();
   end
endmodule
